//--- rtl/pgst_ctrl.sv
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - integral reset clears and disables integral term
// - function 100 maps integral reset to terminal
// - integral hold freezes integral term
// - function 103 maps integral hold to terminal
// - derivative disable clears differential term
// - function 101 maps derivative disable to terminal
// - negative proportional band sentinel uses base
// - negative integral time sentinel uses base
// - negative differential time sentinel uses base
// - gains chosen by polarity and gain set
// - set two positive sentinel falls to set one
// - set two negative sentinel falls to set two positive
// - set three positive sentinel falls to set one
// - set three negative sentinel falls to positive
// - set four positive sentinel falls to set one
// - two gain switches encode four sets
// - feedback below set point means negative
// - set four negative sentinel falls to positive
module pgst_ctrl
  import pgst_pkg::*;
#(
  parameter int TERMS = PGST_NUM_TERM,
  parameter int DW    = 16
) (
  input  wire logic          ref_clk,
  input  wire logic          reset,
  input  wire logic [11:0]   paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [TERMS-1:0] term_in,
  input  wire logic [DW-1:0] set_point,
  input  wire logic [DW-1:0] feedback,
  input  wire logic [DW-1:0] integral_next,
  input  wire logic [DW-1:0] differential_next,
  output logic      [DW-1:0] integral_term,
  output logic      [DW-1:0] differential_term,
  output logic               integral_enable,
  output logic               differential_enable,
  output logic      [15:0]   proportional_band,
  output logic      [15:0]   integral_time,
  output logic      [15:0]   differential_time,
  output logic      [1:0]    gain_set
);

  if (TERMS < 1 || TERMS > 16 || DW < 2) begin : g_bad_params
    $error("pgst_ctrl: unsupported parameters");
  end

  logic [7:0]  terminal_function_select [TERMS];
  logic [15:0] gain_reg [PGST_NUM_GAIN];
  logic [TERMS-1:0] hit_rst, hit_hold, hit_ddis, hit_lo, hit_hi;
  logic        integral_reset_input;
  logic        integral_hold_input;
  logic        derivative_disable_input;
  logic        gain_switch_low;
  logic        gain_switch_high;
  logic        neg_dev;
  logic        wr_en;
  logic        rd_en;
  logic        term_hit;
  logic        gain_hit;
  logic [5:0]  word_idx;
  logic [31:0] next_prdata;
  logic        next_err;

  pgst_gain_if gif ();
  pgst_gain_resolve u_res (.g(gif));

  // terminal function decode
  genvar t;
  generate
    for (t = 0; t < TERMS; t++) begin : g_term
      assign hit_rst[t]  = term_in[t] && terminal_function_select[t] == PGST_FN_INT_RESET;
      assign hit_hold[t] = term_in[t] && terminal_function_select[t] == PGST_FN_INT_HOLD;
      assign hit_ddis[t] = term_in[t] && terminal_function_select[t] == PGST_FN_DER_DIS;
      assign hit_lo[t]   = term_in[t] && terminal_function_select[t] == PGST_FN_GAIN_LO;
      assign hit_hi[t]   = term_in[t] && terminal_function_select[t] == PGST_FN_GAIN_HI;
    end
  endgenerate

  assign integral_reset_input     = |hit_rst;
  assign integral_hold_input      = |hit_hold;
  assign derivative_disable_input = |hit_ddis;
  assign gain_switch_low          = |hit_lo;
  assign gain_switch_high         = |hit_hi;
  assign neg_dev                  = feedback < set_point;

  // gain selector wiring
  generate
    for (t = 0; t < PGST_NUM_GAIN; t++) begin : g_gain
      assign gif.gain[t] = gain_reg[t];
    end
  endgenerate
  assign gif.set_sel = {gain_switch_high, gain_switch_low};
  assign gif.neg     = neg_dev;

  // apb decode
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;
  assign word_idx = paddr[7:2];
  assign term_hit = paddr[11:8] == 4'h0 && paddr[7:6] == 2'h0
                    && word_idx < 6'(TERMS) && paddr[1:0] == 2'h0;
  assign gain_hit = paddr >= PGST_A_GAIN_BASE && paddr[1:0] == 2'h0
                    && paddr < PGST_A_GAIN_BASE + 12'(PGST_NUM_GAIN * 4);

  // terminal selections
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < TERMS; i++) begin
        terminal_function_select[i] <= PGST_FN_RESET;
      end
    end else if (wr_en && term_hit && pstrb[0]) begin
      terminal_function_select[word_idx[3:0]] <= pwdata[7:0];
    end
  end

  // gain parameters
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < PGST_NUM_GAIN; i++) begin
        gain_reg[i] <= PGST_RESET_VALUE;
      end
    end else if (wr_en && gain_hit) begin
      for (int b = 0; b < 2; b++) begin
        if (pstrb[b]) begin
          gain_reg[5'(word_idx - 6'h10)][b*8 +: 8] <= pwdata[b*8 +: 8];
        end
      end
    end
  end

  // apb read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err    = 1'b0;
    if (term_hit) begin
      next_prdata[7:0] = terminal_function_select[word_idx[3:0]];
    end else if (gain_hit) begin
      next_prdata[15:0] = gain_reg[5'(word_idx - 6'h10)];
    end else if (paddr == PGST_A_STATUS) begin
      next_prdata[PGST_ST_INT_EN]          = integral_enable;
      next_prdata[PGST_ST_INT_HOLD]        = integral_hold_input && !integral_reset_input;
      next_prdata[PGST_ST_DER_EN]          = differential_enable;
      next_prdata[PGST_ST_NEG]             = neg_dev;
      next_prdata[PGST_ST_SET_LSB +: 2]    = gain_set;
    end else if (paddr == PGST_A_PB_OUT) begin
      next_prdata[15:0] = proportional_band;
    end else if (paddr == PGST_A_IT_OUT) begin
      next_prdata[15:0] = integral_time;
    end else if (paddr == PGST_A_DT_OUT) begin
      next_prdata[15:0] = differential_time;
    end else begin
      next_err = 1'b1;
    end
  end

  // setup-cycle capture, zero-wait answer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && next_err;
      if (rd_en) begin
        prdata <= next_prdata;
      end
    end
  end

  // integral term
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      integral_term   <= '0;
      integral_enable <= 1'b0;
    end else if (integral_reset_input) begin
      integral_term   <= '0;
      integral_enable <= 1'b0;
    end else if (integral_hold_input) begin
      integral_enable <= 1'b0;
    end else begin
      integral_term   <= integral_next;
      integral_enable <= 1'b1;
    end
  end

  // differential term
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      differential_term   <= '0;
      differential_enable <= 1'b0;
    end else if (derivative_disable_input) begin
      differential_term   <= '0;
      differential_enable <= 1'b0;
    end else begin
      differential_term   <= differential_next;
      differential_enable <= 1'b1;
    end
  end

  // resolved gains
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      proportional_band <= PGST_RESET_VALUE;
      integral_time     <= PGST_RESET_VALUE;
      differential_time <= PGST_RESET_VALUE;
      gain_set          <= 2'h0;
    end else begin
      proportional_band <= gif.pb;
      integral_time     <= gif.it;
      differential_time <= gif.dt;
      gain_set          <= gif.set_sel;
    end
  end

  // checks
  sequence s_rst_seen;
    integral_reset_input;
  endsequence

  property p_int_clear;
    @(posedge ref_clk) disable iff (reset)
      s_rst_seen |=> integral_term == '0 && !integral_enable;
  endproperty
  chk_int_reset_clear: assert property (p_int_clear)
    else $error("integral term not cleared on reset input");

  chk_int_hold_keep: assert property (
    @(posedge ref_clk) disable iff (reset)
      integral_hold_input && !integral_reset_input ##1 1'b1
      |-> integral_term == $past(integral_term))
    else $error("integral term changed while held");

  chk_reset_over_hold: assert property (
    @(posedge ref_clk) disable iff (reset)
      integral_reset_input && integral_hold_input |=> integral_term == '0)
    else $error("hold won over reset");

  chk_der_disable: assert property (
    @(posedge ref_clk) disable iff (reset)
      derivative_disable_input |=> differential_term == '0 && !differential_enable)
    else $error("differential term not cleared");

  generate
    for (t = 0; t < TERMS; t++) begin : g_map_chk
      chk_term_map_rst: assert property (
        @(posedge ref_clk) disable iff (reset)
          term_in[t] && terminal_function_select[t] == PGST_FN_INT_RESET
          |=> integral_term == '0 && !integral_enable)
        else $error("mapped integral reset had no effect");

      chk_term_map_hold: assert property (
        @(posedge ref_clk) disable iff (reset)
          term_in[t] && terminal_function_select[t] == PGST_FN_INT_HOLD && !integral_reset_input
          |=> !integral_enable && integral_term == $past(integral_term))
        else $error("mapped integral hold had no effect");

      chk_term_map_ddis: assert property (
        @(posedge ref_clk) disable iff (reset)
          term_in[t] && terminal_function_select[t] == PGST_FN_DER_DIS
          |=> differential_term == '0 && !differential_enable)
        else $error("mapped derivative disable had no effect");
    end
  endgenerate

  chk_set_encode: assert property (
    @(posedge ref_clk) disable iff (reset)
      1'b1 |=> gain_set == {$past(gain_switch_high), $past(gain_switch_low)})
    else $error("gain set encoding wrong");

  chk_neg_base_pb: assert property (
    @(posedge ref_clk) disable iff (reset)
      gif.set_sel == 2'h0 && neg_dev && gain_reg[1] == PGST_SENTINEL
      |=> proportional_band == $past(gain_reg[0]))
    else $error("negative band did not fall back to base");

  chk_set2_neg_fall: assert property (
    @(posedge ref_clk) disable iff (reset)
      gif.set_sel == 2'h1 && neg_dev && gain_reg[7] == PGST_SENTINEL
      && gain_reg[6] != PGST_SENTINEL |=> proportional_band == $past(gain_reg[6]))
    else $error("set two negative fallback wrong");

  chk_set3_pos_fall: assert property (
    @(posedge ref_clk) disable iff (reset)
      gif.set_sel == 2'h2 && !neg_dev && gain_reg[14] == PGST_SENTINEL
      |=> integral_time == $past(gain_reg[2]))
    else $error("set three positive fallback wrong");

  chk_neg_base_it: assert property (
    @(posedge ref_clk) disable iff (reset)
      gif.set_sel == 2'h0 && neg_dev && gain_reg[3] == PGST_SENTINEL
      |=> integral_time == $past(gain_reg[2]))
    else $error("negative integral time did not fall back to base");

  chk_neg_base_dt: assert property (
    @(posedge ref_clk) disable iff (reset)
      gif.set_sel == 2'h0 && neg_dev && gain_reg[5] == PGST_SENTINEL
      |=> differential_time == $past(gain_reg[4]))
    else $error("negative differential time did not fall back to base");

  chk_pos_base_pb: assert property (
    @(posedge ref_clk) disable iff (reset)
      gif.set_sel == 2'h0 && !neg_dev
      |=> proportional_band == $past(gain_reg[0]))
    else $error("first set positive band wrong");

  chk_neg_own_pb: assert property (
    @(posedge ref_clk) disable iff (reset)
      gif.set_sel == 2'h0 && neg_dev && gain_reg[1] != PGST_SENTINEL
      |=> proportional_band == $past(gain_reg[1]))
    else $error("negative band not used below set point");

  chk_set2_pos_fall: assert property (
    @(posedge ref_clk) disable iff (reset)
      gif.set_sel == 2'h1 && !neg_dev && gain_reg[8] == PGST_SENTINEL
      |=> integral_time == $past(gain_reg[2]))
    else $error("set two positive fallback wrong");

  chk_set3_neg_fall: assert property (
    @(posedge ref_clk) disable iff (reset)
      gif.set_sel == 2'h2 && neg_dev && gain_reg[17] == PGST_SENTINEL
      && gain_reg[16] != PGST_SENTINEL |=> differential_time == $past(gain_reg[16]))
    else $error("set three negative fallback wrong");

  chk_set4_pos_fall: assert property (
    @(posedge ref_clk) disable iff (reset)
      gif.set_sel == 2'h3 && !neg_dev && gain_reg[22] == PGST_SENTINEL
      |=> differential_time == $past(gain_reg[4]))
    else $error("set four positive fallback wrong");

  chk_set4_neg_fall: assert property (
    @(posedge ref_clk) disable iff (reset)
      gif.set_sel == 2'h3 && neg_dev && gain_reg[19] == PGST_SENTINEL
      && gain_reg[18] != PGST_SENTINEL |=> proportional_band == $past(gain_reg[18]))
    else $error("set four negative fallback wrong");

endmodule : pgst_ctrl

//--- rtl/pgst_gain_if.sv
`timescale 1ns/1ps
interface pgst_gain_if;
  logic [15:0] gain [24];
  logic [1:0]  set_sel;
  logic        neg;
  logic [15:0] pb;
  logic [15:0] it;
  logic [15:0] dt;
  modport ctrl (output gain, output set_sel, output neg, input pb, input it, input dt);
  modport sel  (input gain, input set_sel, input neg, output pb, output it, output dt);
endinterface : pgst_gain_if

//--- rtl/pgst_gain_resolve.sv
`timescale 1ns/1ps
module pgst_gain_resolve
  import pgst_pkg::*;
(
  pgst_gain_if.sel g
);

  function automatic logic [15:0] pgst_pick(input logic [15:0] own, input logic [15:0] alt);
    pgst_pick = (own == PGST_SENTINEL) ? alt : own;
  endfunction : pgst_pick

  logic [15:0] res [3];

  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_kind
      logic [15:0] b_pos;
      logic [15:0] b_neg;
      logic [15:0] s_pos;
      always_comb begin
        b_pos = g.gain[k*2];
        b_neg = pgst_pick(g.gain[k*2+1], b_pos);
        s_pos = pgst_pick(g.gain[g.set_sel*6+k*2], g.neg ? b_neg : b_pos);
        if (g.set_sel == 2'h0) begin
          res[k] = g.neg ? b_neg : b_pos;
        end else if (g.neg) begin
          res[k] = pgst_pick(g.gain[g.set_sel*6+k*2+1],
                             pgst_pick(g.gain[g.set_sel*6+k*2], b_neg));
        end else begin
          res[k] = s_pos;
        end
      end
    end
  endgenerate

  assign g.pb = res[0];
  assign g.it = res[1];
  assign g.dt = res[2];

endmodule : pgst_gain_resolve

//--- rtl/pgst_pkg.sv
package pgst_pkg;

  // parameter value encoding: tenths of percent / tenths of s / hundredths of s
  localparam logic [15:0] PGST_SENTINEL     = 16'h270F;  // 9999
  localparam logic [15:0] PGST_PB_MIN       = 16'h0001;  // 0.1 %
  localparam logic [15:0] PGST_PB_MAX       = 16'h2710;  // 1000.0 %
  localparam logic [15:0] PGST_IT_MIN       = 16'h0001;  // 0.1 s
  localparam logic [15:0] PGST_IT_MAX       = 16'h8CA0;  // 3600.0 s
  localparam logic [15:0] PGST_DT_MIN       = 16'h0001;  // 0.01 s
  localparam logic [15:0] PGST_DT_MAX       = 16'h03E8;  // 10.00 s
  localparam logic [15:0] PGST_RESET_VALUE  = 16'h270F;

  // terminal function codes
  localparam logic [7:0]  PGST_FN_INT_RESET = 8'h64;     // 100
  localparam logic [7:0]  PGST_FN_DER_DIS   = 8'h65;     // 101
  localparam logic [7:0]  PGST_FN_INT_HOLD  = 8'h67;     // 103
  localparam logic [7:0]  PGST_FN_GAIN_LO   = 8'h78;     // 120
  localparam logic [7:0]  PGST_FN_GAIN_HI   = 8'h79;     // 121
  localparam logic [7:0]  PGST_FN_RESET     = 8'h00;
  localparam int          PGST_NUM_TERM     = 12;        // selections 178..189

  // register map (byte addresses)
  localparam logic [11:0] PGST_A_TERM_BASE  = 12'h000;   // 12 words, one per terminal
  localparam logic [11:0] PGST_A_GAIN_BASE  = 12'h040;   // 24 words: set*6 + kind*2 + neg
  localparam logic [11:0] PGST_A_STATUS     = 12'h100;
  localparam logic [11:0] PGST_A_PB_OUT     = 12'h104;
  localparam logic [11:0] PGST_A_IT_OUT     = 12'h108;
  localparam logic [11:0] PGST_A_DT_OUT     = 12'h10C;
  localparam int          PGST_NUM_GAIN     = 24;

  // status bit positions
  localparam int          PGST_ST_INT_EN    = 0;
  localparam int          PGST_ST_INT_HOLD  = 1;
  localparam int          PGST_ST_DER_EN    = 2;
  localparam int          PGST_ST_NEG       = 3;
  localparam int          PGST_ST_SET_LSB   = 4;

  typedef enum logic [1:0] {PGST_PB, PGST_IT, PGST_DT} pgst_kind_t;

endpackage : pgst_pkg

//--- tb/pgst_term_driver.sv
`timescale 1ns/1ps
module pgst_term_driver (
  input  wire logic        ref_clk,
  output logic      [11:0] term_in,
  output logic      [15:0] set_point,
  output logic      [15:0] feedback,
  output logic      [15:0] integral_next,
  output logic      [15:0] differential_next
);
  integer seed = 94057;

  function automatic logic [15:0] rnd();
    return 16'($random(seed));
  endfunction : rnd

  initial begin
    term_in           = 12'h000;
    set_point         = 16'h0100;
    feedback          = 16'h0100;
    integral_next     = 16'h0000;
    differential_next = 16'h0000;
  end

  // candidate terms keep moving so a held term shows up
  always @(posedge ref_clk) begin
    integral_next     <= rnd();
    differential_next <= rnd();
  end

  // unmapped terminals 5..11 carry noise
  task automatic apply(input logic [2:0] fn, input logic [1:0] set, input logic neg);
    logic [15:0] sp;
    sp = rnd() | 16'h0001;
    @(posedge ref_clk);
    term_in   <= {7'(rnd()), set, fn};
    set_point <= sp;
    feedback  <= neg ? sp - 16'h0001 : sp;
  endtask : apply
endmodule : pgst_term_driver

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import pgst_pkg::*;;
  logic        ref_clk = 1'b0;
  logic        reset   = 1'b1;
  logic [11:0] paddr   = 12'h000;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] term_in;
  logic [15:0] set_point;
  logic [15:0] feedback;
  logic [15:0] integral_next;
  logic [15:0] differential_next;
  logic [15:0] integral_term;
  logic [15:0] differential_term;
  logic        integral_enable;
  logic        differential_enable;
  logic [15:0] proportional_band;
  logic [15:0] integral_time;
  logic [15:0] differential_time;
  logic [1:0]  gain_set;
  logic [33:0] notes[$];
  logic [33:0] note;
  logic [15:0] gm[24];
  logic [15:0] held;
  logic [7:0]  fn_tab[5] = '{PGST_FN_INT_RESET, PGST_FN_INT_HOLD, PGST_FN_DER_DIS,
                             PGST_FN_GAIN_LO, PGST_FN_GAIN_HI};
  int          miscompares = 0;
  int          checks = 0;

  always #50 ref_clk = ~ref_clk;

  pgst_term_driver i_ext (.ref_clk, .term_in, .set_point, .feedback, .integral_next,
    .differential_next);

  pgst_ctrl #(.TERMS(12), .DW(16)) i_dut (.ref_clk, .reset, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .term_in, .set_point, .feedback,
    .integral_next, .differential_next, .integral_term, .differential_term,
    .integral_enable, .differential_enable, .proportional_band, .integral_time,
    .differential_time, .gain_set);

  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: bus got %h want %h", $time, got, exp);
    end
  endtask : chk_bus

  task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: port got %h want %h", $time, got, exp);
    end
  endtask : chk_port

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // one APB transfer; d is write data or expected read data
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
    notes.push_back({!w, err, d});
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // expected gain after sentinel fallback
  function automatic logic [15:0] resolve(int s, int k, logic n);
    logic [15:0] b;
    b = (n && gm[k*2+1] !== PGST_SENTINEL) ? gm[k*2+1] : gm[k*2];
    if (s == 0) return b;
    if (n && gm[s*6+k*2+1] !== PGST_SENTINEL) return gm[s*6+k*2+1];
    return (gm[s*6+k*2] !== PGST_SENTINEL) ? gm[s*6+k*2] : b;
  endfunction : resolve

  // bus monitor takes the oldest note per completed transfer
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) chk_bus(32'h1, 32'h0);
      else begin
        note = notes.pop_front();
        chk_bus({31'h0, pslverr}, {31'h0, note[32]});
        if (note[33]) chk_bus(prdata, note[31:0]);
      end
    end
  end

  initial begin
    #2000000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    logic [2:0] f3;
    for (int i = 0; i < 24; i++) gm[i] = PGST_SENTINEL;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    apb(1'b0, PGST_A_GAIN_BASE + 12'h05C, {16'h0, PGST_RESET_VALUE}, 1'b0);
    i_ext.apply(3'b111, 2'b11, 1'b1);
    repeat (3) @(posedge ref_clk);
    apb(1'b0, PGST_A_STATUS, 32'h0000000D, 1'b0);
    apb(1'b0, 12'h200, 32'h0, 1'b1);
    apb(1'b1, 12'h002, 32'h1, 1'b1);
    apb(1'b0, PGST_A_TERM_BASE, 32'h0, 1'b0);
    foreach (fn_tab[i]) apb(1'b1, 12'(4*i), {24'h0, fn_tab[i]}, 1'b0);
    apb(1'b0, 12'h008, {24'h0, PGST_FN_DER_DIS}, 1'b0);
    for (int f = 0; f < 8; f++) begin
      f3 = 3'(f);
      i_ext.apply(f3, 2'b00, 1'b0);
      repeat (3) @(posedge ref_clk);
      apb(1'b0, PGST_A_STATUS, {29'h0, !f3[2], f3[1] & !f3[0], !(f3[0] | f3[1])}, 1'b0);
      held = integral_term;
      repeat (2) @(posedge ref_clk);
      if (f3[0]) chk_port(integral_term, 16'h0);
      else if (f3[1]) chk_port(integral_term, held);
      if (f3[2]) chk_port(differential_term, 16'h0);
      chk_port({15'h0, integral_enable}, {15'h0, !(f3[0] | f3[1])});
      chk_port({15'h0, differential_enable}, {15'h0, !f3[2]});
    end
    for (int t = 0; t < 4; t++) begin
      for (int i = 0; i < 24; i++) begin
        gm[i] = (i_ext.rnd() & 16'h1) ? PGST_SENTINEL : (i_ext.rnd() & 16'h03FF) + 16'h1;
        apb(1'b1, PGST_A_GAIN_BASE + 12'(4*i), {16'h0, gm[i]}, 1'b0);
      end
      apb(1'b0, PGST_A_GAIN_BASE + 12'(20*t), {16'h0, gm[5*t]}, 1'b0);
      for (int c = 0; c < 8; c++) begin
        i_ext.apply(3'b000, 2'(c / 2), c[0]);
        repeat (3) @(posedge ref_clk);
        apb(1'b0, PGST_A_STATUS, 32'((c / 2) * 16 + (c % 2) * 8 + 5), 1'b0);
        apb(1'b0, PGST_A_PB_OUT, {16'h0, resolve(c / 2, 0, c[0])}, 1'b0);
        apb(1'b0, PGST_A_IT_OUT, {16'h0, resolve(c / 2, 1, c[0])}, 1'b0);
        apb(1'b0, PGST_A_DT_OUT, {16'h0, resolve(c / 2, 2, c[0])}, 1'b0);
        chk_port({14'h0, gain_set}, 16'(c / 2));
        chk_port(proportional_band, resolve(c / 2, 0, c[0]));
        chk_port(integral_time, resolve(c / 2, 1, c[0]));
        chk_port(differential_time, resolve(c / 2, 2, c[0]));
      end
    end
    @(posedge ref_clk);
    if (notes.size() != 0) miscompares++;
    tally_and_finish();
  end
endmodule : tb_top
